//--- common/spbp_defs.vh
// Register offset, field positions and reset values of the serial pin port
`ifndef SPBP_DEFS_VH
`define SPBP_DEFS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SPBP_ADDR_W 8
`define SPBP_DATA_W 8
`define SPBP_ADDR_SERIAL_PIN_CONTROL 8'h0a

// ----------------------------------------------------------------
// Field positions of serial_pin_control
// ----------------------------------------------------------------
`define SPBP_BIT_PHY_RESET_RELEASE 7
`define SPBP_BIT_MGMT_CLOCK_LEVEL 6
`define SPBP_BIT_MGMT_DRIVE_ENABLE 5
`define SPBP_BIT_MGMT_DATA 4
`define SPBP_BIT_MGMT_OUTPUT_ENABLE 3
`define SPBP_BIT_EEPROM_CLOCK_LEVEL 2
`define SPBP_BIT_EEPROM_DRIVE_ENABLE 1
`define SPBP_BIT_EEPROM_DATA 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPBP_RST_BIT 1'b0
`define SPBP_RST_BYTE 8'h00
`define SPBP_RST_OE_N 1'b1

`endif

//--- src/spbp_pin_sync.v
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/100ps

module spbp_pin_sync (
	input wire i_clk_sys,
	input wire i_reset,
	input wire i_pin,
	output reg o_level
);

	// ----------------------------------------------------------------
	// Synchroniser stages
	// ----------------------------------------------------------------
	reg stage1;
	reg stage2;
	reg stage3;

	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
			o_level <= 1'b0;
		end else begin
			stage1 <= i_pin; // RULE15
			stage2 <= stage1; // RULE15
			stage3 <= stage2;
			if (stage2 == stage3) begin
				o_level <= stage3;
			end
		end
	end

endmodule // spbp_pin_sync

//--- src/spbp_serial_pin_port.v
// Register-driven pin port for the PHY management and EEPROM serial links
// Operation
// RULE1: PHY reset pin follows bit seven
// RULE2: Reset-release bit holds value, resets low
// RULE3: Back-to-back low then high writes accepted
// RULE4: PHY reset driven only with output enable
// RULE5: Management clock pin follows bit six
// RULE6: Drive enable set: MDIO carries data bit
// RULE7: Drive enable clear: release MDIO, sample it
// RULE8: Output enable gates all three management outputs
// RULE9: EEPROM clock pin follows bit two
// RULE10: EEPROM drive enable: pin carries data bit
// RULE11: EEPROM drive clear: release, sample pin
// RULE12: Data bits show pins, others reset zero
// RULE13: Writes move pins, reads return samples
// RULE14: Release management outputs when not master
// RULE15: Sampled pins pass a synchroniser first
`timescale 1ns/100ps
`include "spbp_defs.vh"

module spbp_serial_pin_port (
	input wire i_clk_sys,
	input wire i_reset,
	// Register port
	input wire i_dio_sel,
	input wire i_dio_wr,
	input wire [`SPBP_ADDR_W-1:0] i_dio_addr,
	input wire [`SPBP_DATA_W-1:0] i_dio_wdata,
	output reg [`SPBP_DATA_W-1:0] o_dio_rdata,
	output reg o_dio_ack,
	// PHY management link
	input wire i_mgmt_data_pin,
	output wire o_mgmt_data_pin,
	output wire o_mgmt_data_pin_oe_n,
	output wire o_mgmt_clock_pin,
	output wire o_mgmt_clock_pin_oe_n,
	output wire o_phy_reset_pin,
	output wire o_phy_reset_pin_oe_n,
	// EEPROM link
	output wire o_eeprom_clock_pin,
	input wire i_eeprom_data_pin,
	output wire o_eeprom_data_pin,
	output wire o_eeprom_data_pin_oe_n
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function addr_hit;
		input [`SPBP_ADDR_W-1:0] addr;
		begin
			addr_hit = (addr == `SPBP_ADDR_SERIAL_PIN_CONTROL);
		end
	endfunction

	// New value of a data bit: sample when released, else written value
	function data_next;
		input drive_next;
		input wr;
		input wr_value;
		input held;
		input sampled;
		begin
			if (!drive_next) begin
				data_next = sampled;
			end else if (wr) begin
				data_next = wr_value;
			end else begin
				data_next = held;
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Register bits
	// ----------------------------------------------------------------
	reg phy_reset_release;
	reg mgmt_clock_level;
	reg mgmt_drive_enable;
	reg mgmt_data_bit;
	reg mgmt_output_enable;
	reg eeprom_clock_level;
	reg eeprom_drive_enable;
	reg eeprom_data_bit;

	reg next_phy_reset_release;
	reg next_mgmt_clock_level;
	reg next_mgmt_drive_enable;
	reg next_mgmt_data_bit;
	reg next_mgmt_output_enable;
	reg next_eeprom_clock_level;
	reg next_eeprom_drive_enable;
	reg next_eeprom_data_bit;

	wire mgmt_data_sampled;
	wire eeprom_data_sampled;
	wire reg_write;
	wire reg_read;
	wire unmapped_read;
	reg [`SPBP_DATA_W-1:0] sio_value;
	reg [`SPBP_DATA_W-1:0] next_rdata;

	reg phy_reset_oe_n;
	reg mgmt_clock_oe_n;
	reg mgmt_data_oe_n;
	reg eeprom_data_oe_n;
	reg next_phy_reset_oe_n;
	reg next_mgmt_clock_oe_n;
	reg next_mgmt_data_oe_n;
	reg next_eeprom_data_oe_n;

	// ----------------------------------------------------------------
	// Inbound pin synchronisers
	// ----------------------------------------------------------------
	spbp_pin_sync u_mgmt_data_sync (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_pin(i_mgmt_data_pin),
		.o_level(mgmt_data_sampled)
	); // RULE15

	spbp_pin_sync u_eeprom_data_sync (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_pin(i_eeprom_data_pin),
		.o_level(eeprom_data_sampled)
	); // RULE15

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	assign reg_write = i_dio_sel & i_dio_wr & addr_hit(i_dio_addr);
	assign reg_read = i_dio_sel & ~i_dio_wr & addr_hit(i_dio_addr);
	assign unmapped_read = i_dio_sel & ~i_dio_wr & ~addr_hit(i_dio_addr);

	// ----------------------------------------------------------------
	// Next values of the control bits
	// ----------------------------------------------------------------
	always @* begin
		next_phy_reset_release = phy_reset_release;
		next_mgmt_clock_level = mgmt_clock_level;
		next_mgmt_drive_enable = mgmt_drive_enable;
		next_mgmt_output_enable = mgmt_output_enable;
		next_eeprom_clock_level = eeprom_clock_level;
		next_eeprom_drive_enable = eeprom_drive_enable;
		if (reg_write) begin
			// Held until rewritten, any write spacing accepted
			next_phy_reset_release =
				i_dio_wdata[`SPBP_BIT_PHY_RESET_RELEASE]; // RULE2 RULE3
			next_mgmt_clock_level =
				i_dio_wdata[`SPBP_BIT_MGMT_CLOCK_LEVEL]; // RULE13
			next_mgmt_drive_enable =
				i_dio_wdata[`SPBP_BIT_MGMT_DRIVE_ENABLE]; // RULE13
			next_mgmt_output_enable =
				i_dio_wdata[`SPBP_BIT_MGMT_OUTPUT_ENABLE]; // RULE13
			next_eeprom_clock_level =
				i_dio_wdata[`SPBP_BIT_EEPROM_CLOCK_LEVEL]; // RULE13
			next_eeprom_drive_enable =
				i_dio_wdata[`SPBP_BIT_EEPROM_DRIVE_ENABLE]; // RULE13
		end
	end

	// ----------------------------------------------------------------
	// Next values of the data bits
	// ----------------------------------------------------------------
	always @* begin
		next_mgmt_data_bit = data_next(
			next_mgmt_drive_enable,
			reg_write,
			i_dio_wdata[`SPBP_BIT_MGMT_DATA],
			mgmt_data_bit,
			mgmt_data_sampled); // RULE7
		next_eeprom_data_bit = data_next(
			next_eeprom_drive_enable,
			reg_write,
			i_dio_wdata[`SPBP_BIT_EEPROM_DATA],
			eeprom_data_bit,
			eeprom_data_sampled); // RULE11
	end

	// ----------------------------------------------------------------
	// Control register flops
	// ----------------------------------------------------------------
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			phy_reset_release <= `SPBP_RST_BIT; // RULE2 RULE12
			mgmt_clock_level <= `SPBP_RST_BIT; // RULE12
			mgmt_drive_enable <= `SPBP_RST_BIT; // RULE12
			mgmt_output_enable <= `SPBP_RST_BIT; // RULE8 RULE12
			eeprom_clock_level <= `SPBP_RST_BIT; // RULE12
			eeprom_drive_enable <= `SPBP_RST_BIT; // RULE12
		end else begin
			phy_reset_release <= next_phy_reset_release;
			mgmt_clock_level <= next_mgmt_clock_level;
			mgmt_drive_enable <= next_mgmt_drive_enable;
			mgmt_output_enable <= next_mgmt_output_enable;
			eeprom_clock_level <= next_eeprom_clock_level;
			eeprom_drive_enable <= next_eeprom_drive_enable;
		end
	end

	// ----------------------------------------------------------------
	// Data bit flops
	// ----------------------------------------------------------------
	// Drive enables are low after reset, so both bits track their pins
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			mgmt_data_bit <= `SPBP_RST_BIT;
			eeprom_data_bit <= `SPBP_RST_BIT;
		end else begin
			mgmt_data_bit <= next_mgmt_data_bit; // RULE12
			eeprom_data_bit <= next_eeprom_data_bit; // RULE12
		end
	end

	// ----------------------------------------------------------------
	// Output enable flops
	// ----------------------------------------------------------------
	// One flop per pad enable, so a shared line never sees a decode glitch
	always @* begin
		next_phy_reset_oe_n = ~next_mgmt_output_enable; // RULE4 RULE8
		next_mgmt_clock_oe_n = ~next_mgmt_output_enable; // RULE5 RULE8
		next_mgmt_data_oe_n =
			~(next_mgmt_output_enable & next_mgmt_drive_enable); // RULE14
		next_eeprom_data_oe_n = ~next_eeprom_drive_enable; // RULE11
	end

	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			phy_reset_oe_n <= `SPBP_RST_OE_N; // RULE8
			mgmt_clock_oe_n <= `SPBP_RST_OE_N; // RULE8
			mgmt_data_oe_n <= `SPBP_RST_OE_N; // RULE8
			eeprom_data_oe_n <= `SPBP_RST_OE_N;
		end else begin
			phy_reset_oe_n <= next_phy_reset_oe_n;
			mgmt_clock_oe_n <= next_mgmt_clock_oe_n;
			mgmt_data_oe_n <= next_mgmt_data_oe_n;
			eeprom_data_oe_n <= next_eeprom_data_oe_n;
		end
	end

	// ----------------------------------------------------------------
	// Management link pins
	// ----------------------------------------------------------------
	assign o_phy_reset_pin = phy_reset_release; // RULE1
	assign o_phy_reset_pin_oe_n = phy_reset_oe_n; // RULE4 RULE8

	assign o_mgmt_clock_pin = mgmt_clock_level; // RULE5
	assign o_mgmt_clock_pin_oe_n = mgmt_clock_oe_n; // RULE5 RULE8

	// Shared link: released unless this port is the active master
	assign o_mgmt_data_pin = mgmt_data_bit; // RULE6
	assign o_mgmt_data_pin_oe_n = mgmt_data_oe_n; // RULE6 RULE7 RULE14

	// ----------------------------------------------------------------
	// EEPROM link pins
	// ----------------------------------------------------------------
	assign o_eeprom_clock_pin = eeprom_clock_level; // RULE9

	assign o_eeprom_data_pin = eeprom_data_bit; // RULE10
	assign o_eeprom_data_pin_oe_n = eeprom_data_oe_n; // RULE10 RULE11

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always @* begin
		sio_value = `SPBP_RST_BYTE;
		sio_value[`SPBP_BIT_PHY_RESET_RELEASE] = phy_reset_release;
		sio_value[`SPBP_BIT_MGMT_CLOCK_LEVEL] = mgmt_clock_level;
		sio_value[`SPBP_BIT_MGMT_DRIVE_ENABLE] = mgmt_drive_enable;
		sio_value[`SPBP_BIT_MGMT_DATA] = mgmt_data_bit;
		sio_value[`SPBP_BIT_MGMT_OUTPUT_ENABLE] = mgmt_output_enable;
		sio_value[`SPBP_BIT_EEPROM_CLOCK_LEVEL] = eeprom_clock_level;
		sio_value[`SPBP_BIT_EEPROM_DRIVE_ENABLE] = eeprom_drive_enable;
		sio_value[`SPBP_BIT_EEPROM_DATA] = eeprom_data_bit;
	end

	always @* begin
		next_rdata = o_dio_rdata;
		if (reg_read) begin
			next_rdata = sio_value; // RULE13
		end else if (unmapped_read) begin
			next_rdata = `SPBP_RST_BYTE;
		end
	end

	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_dio_ack <= 1'b0;
		end else begin
			o_dio_ack <= i_dio_sel;
		end
	end

	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_dio_rdata <= `SPBP_RST_BYTE;
		end else begin
			o_dio_rdata <= next_rdata;
		end
	end

endmodule // spbp_serial_pin_port

//--- dv/spbp_far_end.sv
// Far-end model of the PHY management link and the EEPROM data line
`timescale 1ns/100ps
module spbp_far_end (
	input wire i_dev_mdio,
	input wire i_dev_mdio_oe_n,
	input wire i_phy_en,
	input wire i_phy_val,
	input wire i_dev_ee,
	input wire i_dev_ee_oe_n,
	input wire i_ee_val,
	input wire i_lnk_clk,
	output wire o_mdio,
	output wire o_ee,
	output wire o_clash
);
	// Released line floats to the pull-up level
	assign o_mdio = !i_dev_mdio_oe_n ? i_dev_mdio :
		(i_phy_en ? i_phy_val : 1'b1);
	// EEPROM answers only while the device releases the line
	assign o_ee = !i_dev_ee_oe_n ? i_dev_ee : i_ee_val ^ i_lnk_clk;
	// Two masters on the management line at once
	assign o_clash = !i_dev_mdio_oe_n && i_phy_en;
endmodule // spbp_far_end

//--- dv/spbp_monitor.sv
// Port checker of the serial pin port
`timescale 1ns/100ps
module spbp_monitor (
	input wire i_clk_sys,
	input wire i_reset,
	input wire i_dio_sel,
	input wire i_dio_wr,
	input wire [7:0] i_dio_addr,
	input wire [7:0] i_dio_wdata,
	input wire [7:0] o_dio_rdata,
	input wire o_dio_ack,
	input wire i_mgmt_data_pin,
	input wire o_mgmt_data_pin,
	input wire o_mgmt_data_pin_oe_n,
	input wire o_mgmt_clock_pin,
	input wire o_mgmt_clock_pin_oe_n,
	input wire o_phy_reset_pin,
	input wire o_phy_reset_pin_oe_n,
	input wire o_eeprom_clock_pin,
	input wire i_eeprom_data_pin,
	input wire o_eeprom_data_pin,
	input wire o_eeprom_data_pin_oe_n
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	wire wr = i_dio_sel && i_dio_wr && i_dio_addr == 8'h0a;
	wire rd = i_dio_sel && !i_dio_wr;
	rst_pin_a: assert property (wr |=>
		o_phy_reset_pin == $past(i_dio_wdata[7])) else $error("reset pin");
	rst_hold_a: assert property (!wr |=>
		$stable(o_phy_reset_pin)) else $error("reset pin moved");
	mgmt_gate_a: assert property (o_phy_reset_pin_oe_n ==
		o_mgmt_clock_pin_oe_n && (o_mgmt_clock_pin_oe_n ->
		o_mgmt_data_pin_oe_n)) else $error("mgmt enables");
	clk_pin_a: assert property (wr |=>
		o_mgmt_clock_pin == $past(i_dio_wdata[6]) &&
		o_mgmt_clock_pin_oe_n == !$past(i_dio_wdata[3]))
		else $error("mgmt clock");
	mdio_drive_a: assert property (wr && i_dio_wdata[5]
		&& i_dio_wdata[3] |=> !o_mgmt_data_pin_oe_n &&
		o_mgmt_data_pin == $past(i_dio_wdata[4])) else $error("mdio drive");
	ee_drive_a: assert property (wr |=>
		o_eeprom_clock_pin == $past(i_dio_wdata[2]) &&
		o_eeprom_data_pin_oe_n == !$past(i_dio_wdata[1]))
		else $error("eeprom pins");
	ee_sample_a: assert property ((o_eeprom_data_pin_oe_n &&
		$stable(i_eeprom_data_pin))[*8] |-> o_eeprom_data_pin ==
		i_eeprom_data_pin) else $error("eeprom sample");
	mdio_sample_a: assert property ((o_mgmt_data_pin_oe_n &&
		!o_mgmt_clock_pin_oe_n &&
		$stable(i_mgmt_data_pin))[*8] |-> o_mgmt_data_pin ==
		i_mgmt_data_pin) else $error("mdio sample");
	read_back_a: assert property (rd && i_dio_addr == 8'h0a |=>
		o_dio_ack && o_dio_rdata[7:6] == {o_phy_reset_pin,
		o_mgmt_clock_pin} && o_dio_rdata[4] == $past(o_mgmt_data_pin) &&
		o_dio_rdata[3] == !o_mgmt_clock_pin_oe_n &&
		o_dio_rdata[2:0] == {o_eeprom_clock_pin, !o_eeprom_data_pin_oe_n,
		$past(o_eeprom_data_pin)}) else $error("read back");
	ack_pulse_a: assert property (o_dio_ack ==
		$past(i_dio_sel)) else $error("ack pulse");
	unmapped_rd_a: assert property (rd && i_dio_addr != 8'h0a |=>
		o_dio_ack && o_dio_rdata == 8'h00) else $error("unmapped read");
	cover property (wr ##1 wr);
	cover property (rd);
	cover property (o_eeprom_data_pin_oe_n && i_eeprom_data_pin);
endmodule // spbp_monitor
bind spbp_serial_pin_port spbp_monitor u_mon (.*);

//--- dv/tb.sv
// Self-checking testbench of the serial pin port
`timescale 1ns/100ps
`include "spbp_defs.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
	$display("[ERR] %0t got %h want %h", $time, a, e); end end
module tb;
	localparam [7:0] ctl = `SPBP_ADDR_SERIAL_PIN_CONTROL;
	reg clk = 0, rst = 1, sel = 0, wr = 0, phy_en = 0, phy_v = 0;
	reg ee_v = 0, lnk = 0, lnk_on = 0;
	reg [7:0] addr = 0, wd = 0;
	wire [7:0] rdata;
	wire ack, mdo, mdo_n, mck, mck_n, prs, prs_n, eck, edo, edo_n;
	wire mdi, edi, clash;
	int err_total = 0, checks = 0;
	always #20 clk = ~clk;
	initial #13 forever #160 lnk = lnk_on ? ~lnk : 1'b0;
	spbp_serial_pin_port uut (.i_clk_sys(clk), .i_reset(rst),
		.i_dio_sel(sel), .i_dio_wr(wr), .i_dio_addr(addr),
		.i_dio_wdata(wd), .o_dio_rdata(rdata), .o_dio_ack(ack),
		.i_mgmt_data_pin(mdi), .o_mgmt_data_pin(mdo),
		.o_mgmt_data_pin_oe_n(mdo_n), .o_mgmt_clock_pin(mck),
		.o_mgmt_clock_pin_oe_n(mck_n), .o_phy_reset_pin(prs),
		.o_phy_reset_pin_oe_n(prs_n), .o_eeprom_clock_pin(eck),
		.i_eeprom_data_pin(edi), .o_eeprom_data_pin(edo),
		.o_eeprom_data_pin_oe_n(edo_n));
	spbp_far_end u_far (.i_dev_mdio(mdo), .i_dev_mdio_oe_n(mdo_n),
		.i_phy_en(phy_en), .i_phy_val(phy_v), .i_dev_ee(edo),
		.i_dev_ee_oe_n(edo_n), .i_ee_val(ee_v), .i_lnk_clk(lnk),
		.o_mdio(mdi), .o_ee(edi), .o_clash(clash));
	task acc(input w, input [7:0] a, input [7:0] d);
		sel <= 1'b1;
		wr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
	endtask
	task idle(input int n);
		sel <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	task rd(input [7:0] a);
		acc(0, a, 8'h00);
		idle(1);
	endtask
	task note(input int n);
		$display("test %0d done", n);
	endtask
	task finish_test;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#400000;
		err_total++;
		finish_test;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		idle(8);
		rd(ctl);
		`CHK(rdata, 8'h10)
		`CHK({mck_n, prs_n, mdo_n, eck}, 4'he)
		note(1);
		acc(1, ctl, 8'h78);
		acc(1, ctl, 8'hf8);
		idle(1);
		`CHK({prs, prs_n, mck, mck_n, mdo, mdo_n}, 6'b101010)
		rd(ctl);
		`CHK(rdata, 8'hf8)
		note(2);
		acc(1, ctl, 8'h88);
		phy_en <= 1'b1;
		for (int v = 0; v < 2; v++) begin
			phy_v <= v[0];
			idle(8);
			`CHK({clash, mdo_n}, 2'b01)
			rd(ctl);
			`CHK(rdata, {3'b100, v[0], 4'h8})
		end
		note(3);
		acc(1, ctl, 8'hf0);
		idle(1);
		`CHK({prs_n, mck_n, mdo_n}, 3'b111)
		note(4);
		acc(1, ctl, 8'h07);
		idle(1);
		`CHK({eck, edo, edo_n}, 3'b110)
		ee_v <= 1'b1;
		phy_en <= 1'b0;
		acc(1, ctl, 8'h00);
		idle(8);
		`CHK({eck, edo_n}, 2'b01)
		rd(ctl);
		`CHK(rdata, 8'h11)
		note(5);
		acc(1, 8'h0b, 8'hff);
		idle(1);
		rd(8'h0b);
		`CHK(rdata, 8'h00)
		rd(ctl);
		`CHK(rdata, 8'h11)
		note(6);
		lnk_on <= 1'b1;
		idle(64);
		lnk_on <= 1'b0;
		idle(12);
		rd(ctl);
		`CHK(rdata, 8'h11)
		acc(1, ctl, 8'h80);
		rst <= 1'b1;
		idle(2);
		rst <= 1'b0;
		idle(8);
		rd(ctl);
		`CHK(rdata, 8'h11)
		note(7);
		finish_test;
	end
endmodule // tb
